//--- logic/cafe_pkg.sv
// constants, types and helpers for the camera acquisition front end
// assumes a 24-bit pixel link and a 10 MHz system clock
package cafe_pkg;
    localparam int DW = 24;
    localparam int TAPS = 3;
    localparam int CW = 12;
    localparam int PW = 16;
    localparam int FAW = 4;
    localparam int FDEPTH = 16;
    localparam int NBUS = 4;
    localparam int NEXT = 4;
    localparam int NTRIG = 8;
    localparam int NCC = 4;
    localparam int FWW = DW + 2 * TAPS * CW;
    localparam int COL_LSB = DW;
    localparam int ROW_LSB = DW + TAPS * CW;
    localparam logic [4:0] TW_8 = 5'h08;
    localparam logic [4:0] TW_10 = 5'h0a;
    localparam logic [4:0] TW_12 = 5'h0c;
    localparam logic [4:0] TW_14 = 5'h0e;
    localparam logic [4:0] TW_16 = 5'h10;
    localparam logic [1:0] NT_1 = 2'h1;
    localparam logic [1:0] NT_2 = 2'h2;
    localparam logic [1:0] NT_3 = 2'h3;

    // link bit allocations; rgb runs as three 8-bit taps
    typedef enum logic [9:0] {
        F8X1 = 10'h001, F8X2 = 10'h002, F8X3 = 10'h004, F10X1 = 10'h008,
        F10X2 = 10'h010, F12X1 = 10'h020, F12X2 = 10'h040, F14X1 = 10'h080,
        F16X1 = 10'h100, FRGB = 10'h200
    } cafe_fmt_t;
    typedef enum logic [2:0] {BIN_OFF = 3'h1, BIN_ON = 3'h2, BIN_INV = 3'h4} cafe_bin_t;
    typedef enum logic [3:0] {SRC_LVL = 4'h1, SRC_TMR = 4'h2, SRC_BUSY = 4'h4,
        SRC_OVF = 4'h8} cafe_src_t;
    typedef enum logic [3:0] {L_IDLE = 4'h1, L_SKIP = 4'h2, L_CAP = 4'h4,
        L_DONE = 4'h8} cafe_lst_t;

    function automatic logic [9:0] fmt_geom(input cafe_fmt_t f);
        // {tap width, tap count}, zero width for an illegal code
        unique case (f)
            F8X1: fmt_geom = {3'h0, TW_8, NT_1};
            F8X2: fmt_geom = {3'h0, TW_8, NT_2};
            F8X3, FRGB: fmt_geom = {3'h0, TW_8, NT_3};
            F10X1: fmt_geom = {3'h0, TW_10, NT_1};
            F10X2: fmt_geom = {3'h0, TW_10, NT_2};
            F12X1: fmt_geom = {3'h0, TW_12, NT_1};
            F12X2: fmt_geom = {3'h0, TW_12, NT_2};
            F14X1: fmt_geom = {3'h0, TW_14, NT_1};
            F16X1: fmt_geom = {3'h0, TW_16, NT_1};
            default: fmt_geom = 10'h000;
        endcase
    endfunction

    function automatic logic [FAW:0] gray(input logic [FAW:0] b);
        gray = b ^ (b >> 1);
    endfunction
endpackage

//--- logic/cafe_top.sv
// camera acquisition front end: window, binarise, tap order, fifo, triggers
// assumes config inputs stay still while busy_o is high; camera is on pclk_i
//
// Summary of operation
// - accept 8x1-3, 10x1-2, 12x1-2, 14x1, 16x1 and 24-bit rgb layouts
// - binarise: pixel inside threshold becomes white, else zero
// - inverse binarise: inside threshold becomes zero, else white
// - up to three simultaneous taps are placed into one ordered image
// - each tap has its own horizontal and vertical scan direction
// - a fifo buffers pixels so acquisition runs on until it fills
// - only active pixels of valid frames and lines are forwarded
// - each trigger line starts on its rising or its falling edge
// - an output trigger line can be driven to a chosen level
// - trigger lines can carry timer pulses or internal status signals
// - four bus and four external trigger lines with polarity and direction
// - each external trigger uses its pin or an input-only alternate source
// - an external trigger on its alternate source never drives its pin
// - a counter makes single pulses or trains of set period and width
// - camera control k takes the timer or external trigger input k
// - window starts and counts pixels from the line enable edge
// - window starts and counts lines from the frame enable edge
// - a nested region inside the window limits what is acquired
// - software start captures a set number of frames, then stops
// - after a start, capture at once or skip a set number of frames
`timescale 1ns/100ps
module cafe_top (
    // system clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // camera link
    input wire logic pclk_i,
    input wire logic [cafe_pkg::DW-1:0] cam_data_i,
    input wire logic cam_fval_i,
    input wire logic cam_lval_i,
    input wire logic cam_dval_i,
    // pixel processing configuration
    input wire cafe_pkg::cafe_fmt_t fmt_i,
    input wire cafe_pkg::cafe_bin_t bin_mode_i,
    input wire logic [cafe_pkg::PW-1:0] thr_lo_i,
    input wire logic [cafe_pkg::PW-1:0] thr_hi_i,
    input wire logic [cafe_pkg::TAPS-1:0] hdir_i,
    input wire logic [cafe_pkg::TAPS-1:0] vdir_i,
    // window and region of interest
    input wire logic [cafe_pkg::CW-1:0] win_x_i,
    input wire logic [cafe_pkg::CW-1:0] win_w_i,
    input wire logic [cafe_pkg::CW-1:0] win_y_i,
    input wire logic [cafe_pkg::CW-1:0] win_h_i,
    input wire logic [cafe_pkg::CW-1:0] roi_x_i,
    input wire logic [cafe_pkg::CW-1:0] roi_w_i,
    input wire logic [cafe_pkg::CW-1:0] roi_y_i,
    input wire logic [cafe_pkg::CW-1:0] roi_h_i,
    // start control and status
    input wire logic [cafe_pkg::CW-1:0] nframes_i,
    input wire logic [cafe_pkg::CW-1:0] nskip_i,
    input wire logic sw_start_i,
    output logic busy_o,
    output logic ovf_o,
    // pixel stream out
    output logic px_valid_o,
    input wire logic px_ready_i,
    output logic [cafe_pkg::DW-1:0] px_data_o,
    output logic [cafe_pkg::TAPS*cafe_pkg::CW-1:0] px_col_o,
    output logic [cafe_pkg::TAPS*cafe_pkg::CW-1:0] px_row_o,
    // trigger lines: bus lines first, then external lines
    input wire logic [cafe_pkg::NTRIG-1:0] trig_i,
    output logic [cafe_pkg::NTRIG-1:0] trig_o,
    output logic [cafe_pkg::NTRIG-1:0] trig_oe_n_o,
    input wire logic [cafe_pkg::NEXT-1:0] alt_trig_i,
    input wire logic [cafe_pkg::NEXT-1:0] ext_alt_sel_i,
    input wire logic [cafe_pkg::NTRIG-1:0] trig_pol_i,
    input wire logic [cafe_pkg::NTRIG-1:0] trig_dir_out_i,
    input wire logic [cafe_pkg::NTRIG-1:0] trig_start_en_i,
    input wire logic [cafe_pkg::NTRIG-1:0] trig_lvl_i,
    input wire logic [4*cafe_pkg::NTRIG-1:0] trig_src_i,
    // pulse timer
    input wire logic tmr_go_i,
    input wire logic tmr_stop_i,
    input wire logic [15:0] tmr_period_i,
    input wire logic [15:0] tmr_width_i,
    input wire logic [15:0] tmr_count_i,
    // camera control lines
    input wire logic [cafe_pkg::NCC-1:0] cc_sel_i,
    output logic [cafe_pkg::NCC-1:0] cc_o
);
    import cafe_pkg::*;

    // ---- pixel clock domain ----
    logic prst_s1_r, prst_n_r, run_s1_r, run_s_r;
    logic [DW-1:0] cam_d_r;
    logic fval_r, lval_r, dval_r, fval_p_r, lval_p_r;
    logic [CW-1:0] pix_r, line_r, skip_r, frm_r;
    cafe_lst_t st_r;
    logic done_tog_r, idle_r, ovf_r, w_vld_r;
    logic [FWW-1:0] w_dat_r;
    logic [FAW:0] wbin_r, wg_r, rg_s1_r, rg_s_r;
    logic [FWW-1:0] mem_r [FDEPTH];
    logic run_r;
    logic [FAW:0] rg_r;

    // reset release is re-timed to the pixel clock to avoid a split release
    always_ff @(posedge pclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prst_s1_r <= 1'b0;
            prst_n_r <= 1'b0;
        end else begin
            prst_s1_r <= 1'b1;
            prst_n_r <= prst_s1_r;
        end
    end

    // run level and read pointer cross into the pixel domain
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            run_s1_r <= 1'b0;
            run_s_r <= 1'b0;
            rg_s1_r <= '0;
            rg_s_r <= '0;
        end else begin
            run_s1_r <= run_r;
            run_s_r <= run_s1_r;
            rg_s1_r <= rg_r;
            rg_s_r <= rg_s1_r;
        end
    end

    // camera inputs are synchronous to pclk, so one register stage suffices
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            cam_d_r <= '0;
            {fval_r, lval_r, dval_r, fval_p_r, lval_p_r} <= 5'h00;
        end else begin
            cam_d_r <= cam_data_i;
            {fval_r, lval_r, dval_r} <= {cam_fval_i, cam_lval_i, cam_dval_i};
            {fval_p_r, lval_p_r} <= {fval_r, lval_r};
        end
    end

    logic fstart, fend, act, skip_go, cap;
    assign fstart = fval_r & ~fval_p_r;
    assign fend = fval_p_r & ~fval_r;
    assign act = fval_r & lval_r & dval_r;

    // pixel index restarts with each line enable, line index with each frame
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            pix_r <= '0;
            line_r <= '0;
        end else begin
            pix_r <= !lval_r ? '0 : act ? CW'(pix_r + 1'b1) : pix_r;
            line_r <= !fval_r ? '0 : (lval_p_r & ~lval_r) ? CW'(line_r + 1'b1) : line_r;
        end
    end

    // window test, then region test relative to the window origin
    logic [CW-1:0] rx, ry, col, row;
    logic in_win, in_roi, in_fifo_full;
    assign rx = CW'(pix_r - win_x_i);
    assign ry = CW'(line_r - win_y_i);
    assign col = CW'(rx - roi_x_i);
    assign row = CW'(ry - roi_y_i);
    assign in_win = pix_r >= win_x_i && (CW+1)'(pix_r) < (CW+1)'(win_x_i) + (CW+1)'(win_w_i)
        && line_r >= win_y_i && (CW+1)'(line_r) < (CW+1)'(win_y_i) + (CW+1)'(win_h_i);
    assign in_roi = rx >= roi_x_i && (CW+1)'(rx) < (CW+1)'(roi_x_i) + (CW+1)'(roi_w_i)
        && ry >= roi_y_i && (CW+1)'(ry) < (CW+1)'(roi_y_i) + (CW+1)'(roi_h_i);

    // frame sequencer: skip frames, capture a count, wait for run to drop
    assign skip_go = st_r == L_SKIP && fstart && skip_r == '0;
    assign cap = st_r == L_CAP || skip_go;
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            st_r <= L_IDLE;
            skip_r <= '0;
            frm_r <= '0;
            done_tog_r <= 1'b0;
        end else begin
            unique case (st_r)
                L_IDLE: if (run_s_r) begin
                    st_r <= L_SKIP;
                    skip_r <= nskip_i;
                    frm_r <= '0;
                end
                L_SKIP: if (skip_go) begin
                    st_r <= L_CAP;
                end else if (fstart) begin
                    skip_r <= CW'(skip_r - 1'b1);
                end
                L_CAP: if (fend) begin
                    frm_r <= CW'(frm_r + 1'b1);
                    // zero frames matches only once the count wraps, so it means 4096 frames
                    if (CW'(frm_r + 1'b1) == nframes_i) begin
                        st_r <= L_DONE;
                        done_tog_r <= ~done_tog_r;
                    end
                end
                L_DONE: if (!run_s_r) begin
                    st_r <= L_IDLE;
                end
            endcase
        end
    end

    // per-tap binarisation and scan-direction addressing
    logic [9:0] geom;
    logic [4:0] tw;
    logic [1:0] nt;
    logic [PW-1:0] tmask;
    logic [DW-1:0] tap_sh [TAPS];
    logic [TAPS*CW-1:0] tcol, trow;
    assign geom = fmt_geom(fmt_i);
    assign tw = geom[6:2];
    assign nt = geom[1:0];
    assign tmask = PW'((17'h1 << tw) - 17'h1);
    generate
        for (genvar t = 0; t < TAPS; t++) begin : g_tap
            logic [PW-1:0] raw, res;
            logic in_thr;
            assign raw = PW'(cam_d_r >> (t * tw)) & tmask;
            assign in_thr = raw >= thr_lo_i && raw <= thr_hi_i;
            always_comb begin
                unique case (bin_mode_i)
                    BIN_ON: res = in_thr ? tmask : '0;
                    BIN_INV: res = in_thr ? '0 : tmask;
                    default: res = raw;
                endcase
            end
            assign tap_sh[t] = (t < nt) ? DW'(DW'(res) << (t * tw)) : '0;
            assign tcol[t*CW +: CW] = hdir_i[t] ? CW'(roi_w_i - col - 1'b1) : col;
            assign trow[t*CW +: CW] = vdir_i[t] ? CW'(roi_h_i - row - 1'b1) : row;
        end
    endgenerate

    // capture stage: gated by sequencer, window, region and overflow
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            w_vld_r <= 1'b0;
            w_dat_r <= '0;
        end else begin
            w_vld_r <= cap && act && in_win && in_roi && !ovf_r;
            w_dat_r <= {trow, tcol, tap_sh[0] | tap_sh[1] | tap_sh[2]};
        end
    end

    // fifo write side; full compares against the synchronised read gray code
    assign in_fifo_full = wg_r == {~rg_s_r[FAW:FAW-1], rg_s_r[FAW-2:0]};
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            wbin_r <= '0;
            wg_r <= '0;
        end else if (w_vld_r && !in_fifo_full) begin
            wbin_r <= (FAW+1)'(wbin_r + 1'b1);
            wg_r <= gray((FAW+1)'(wbin_r + 1'b1));
        end
    end
    always_ff @(posedge pclk_i) begin
        if (w_vld_r && !in_fifo_full) begin
            mem_r[wbin_r[FAW-1:0]] <= w_dat_r;
        end
    end

    // overflow stays set until the next acquisition starts
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            ovf_r <= 1'b0;
        end else if (w_vld_r && in_fifo_full) begin
            ovf_r <= 1'b1;
        end else if (st_r == L_IDLE && run_s_r) begin
            ovf_r <= 1'b0;
        end
    end
    always_ff @(posedge pclk_i or negedge prst_n_r) begin
        if (!prst_n_r) begin
            idle_r <= 1'b1;
        end else begin
            idle_r <= st_r == L_IDLE;
        end
    end

    a_bin_white: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        w_vld_r && bin_mode_i == BIN_ON && fmt_i == F8X1 |-> (w_dat_r[7:0] == 8'hff) ==
        ($past(cam_d_r[7:0]) >= thr_lo_i[7:0] && $past(cam_d_r[7:0]) <= thr_hi_i[7:0]))
        else $error("binarised pixel does not match threshold test");
    a_inv_white: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        w_vld_r && bin_mode_i == BIN_INV && fmt_i == F8X1 |-> (w_dat_r[7:0] == 8'h00) ==
        ($past(cam_d_r[7:0]) >= thr_lo_i[7:0] && $past(cam_d_r[7:0]) <= thr_hi_i[7:0]))
        else $error("inverse binarised pixel does not match threshold test");
    a_only_active: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        w_vld_r |-> $past(act && cap))
        else $error("pixel written outside an active capture cycle");
    a_ovf_stops: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        w_vld_r && in_fifo_full |=> ovf_r ##1 !w_vld_r)
        else $error("overflow not flagged or writes continue");
    a_frame_done: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        st_r == L_CAP && fend && CW'(frm_r + 1'b1) == nframes_i |=> st_r == L_DONE)
        else $error("capture did not stop after the frame count");
    a_skip_end: assert property (@(posedge pclk_i) disable iff (!prst_n_r)
        st_r == L_SKIP && fstart && skip_r != '0 |=> st_r == L_SKIP)
        else $error("capture began before the skip count ran out");

    // ---- system clock domain ----
    logic idle_s1_r, idle_s_r, dt_s1_r, dt_s_r, dt_p_r, ovf_s1_r;
    logic [FAW:0] wg_s1_r, wg_s_r, rbin_r;
    logic [NTRIG-1:0] tr_s1_r, tr_s_r, ln_p_r, line_in, tedge, tnxt;
    logic [2:0] arm_r;
    logic [NEXT-1:0] alt_s1_r, alt_s_r;
    logic done_evt, start_ok, trig_go, rd;

    // level, pointer and toggle crossings into the system domain
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {idle_s1_r, idle_s_r, dt_s1_r, dt_s_r, dt_p_r, ovf_s1_r} <= 6'h30;
            ovf_o <= 1'b0;
            wg_s1_r <= '0;
            wg_s_r <= '0;
        end else begin
            {idle_s1_r, idle_s_r} <= {idle_r, idle_s1_r};
            {dt_s1_r, dt_s_r, dt_p_r} <= {done_tog_r, dt_s1_r, dt_s_r};
            ovf_s1_r <= ovf_r;
            ovf_o <= ovf_s1_r;
            wg_s1_r <= wg_r;
            wg_s_r <= wg_s1_r;
        end
    end

    // trigger pins and alternate inputs come from outside: two stages each
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tr_s1_r <= '0;
            tr_s_r <= '0;
            alt_s1_r <= '0;
            alt_s_r <= '0;
            ln_p_r <= '0;
            arm_r <= '0;
        end else begin
            tr_s1_r <= trig_i;
            tr_s_r <= tr_s1_r;
            alt_s1_r <= alt_trig_i;
            alt_s_r <= alt_s1_r;
            ln_p_r <= line_in;
            // edges count only once the sync and edge flops hold real pin levels
            arm_r <= {arm_r[1:0], 1'b1};
        end
    end
    assign line_in = {ext_alt_sel_i & alt_s_r | ~ext_alt_sel_i & tr_s_r[NTRIG-1:NBUS],
        tr_s_r[NBUS-1:0]};
    assign tedge = trig_pol_i & ln_p_r & ~line_in | ~trig_pol_i & ~ln_p_r & line_in;
    // a line that idles high would otherwise look like a rising edge after reset
    assign trig_go = &arm_r && |(tedge & trig_start_en_i & ~trig_dir_out_i);
    assign done_evt = dt_s_r ^ dt_p_r;
    assign start_ok = !run_r && idle_s_r && (sw_start_i || trig_go);

    // run level: a new start waits until the link side is back to idle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_r <= 1'b0;
        end else if (done_evt) begin
            run_r <= 1'b0;
        end else if (start_ok) begin
            run_r <= 1'b1;
        end
    end
    assign busy_o = run_r;

    a_start_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
        start_ok && !done_evt |=> busy_o [*2])
        else $error("accepted start did not raise busy");

    // fifo read side feeding a one-word output register
    assign rd = gray(rbin_r) != wg_s_r && (!px_valid_o || px_ready_i);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rbin_r <= '0;
            rg_r <= '0;
            px_valid_o <= 1'b0;
            px_data_o <= '0;
            px_col_o <= '0;
            px_row_o <= '0;
        end else if (rd) begin
            rbin_r <= (FAW+1)'(rbin_r + 1'b1);
            rg_r <= gray((FAW+1)'(rbin_r + 1'b1));
            px_valid_o <= 1'b1;
            px_data_o <= mem_r[rbin_r[FAW-1:0]][DW-1:0];
            px_col_o <= mem_r[rbin_r[FAW-1:0]][COL_LSB +: TAPS*CW];
            px_row_o <= mem_r[rbin_r[FAW-1:0]][ROW_LSB +: TAPS*CW];
        end else if (px_ready_i) begin
            px_valid_o <= 1'b0;
        end
    end

    // pulse timer: count zero keeps the train running until stopped
    logic tmr_run_r, tmr_r;
    logic [15:0] tcnt_r, tleft_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tmr_run_r <= 1'b0;
            tcnt_r <= '0;
            tleft_r <= '0;
        end else if (tmr_stop_i) begin
            tmr_run_r <= 1'b0;
        end else if (tmr_go_i) begin
            tmr_run_r <= 1'b1;
            tcnt_r <= '0;
            tleft_r <= tmr_count_i;
        end else if (tmr_run_r) begin
            if (16'(tcnt_r + 1'b1) >= tmr_period_i) begin
                tcnt_r <= '0;
                if (tleft_r == 16'h0001) begin
                    tmr_run_r <= 1'b0;
                end
                if (tleft_r != '0) begin
                    tleft_r <= 16'(tleft_r - 1'b1);
                end
            end else begin
                tcnt_r <= 16'(tcnt_r + 1'b1);
            end
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tmr_r <= 1'b0;
        end else begin
            tmr_r <= tmr_run_r && !tmr_stop_i && tcnt_r < tmr_width_i;
        end
    end

    // trigger drive: source select, polarity, and direction per line
    generate
        for (genvar i = 0; i < NTRIG; i++) begin : g_trig
            logic v;
            always_comb begin
                unique case (trig_src_i[4*i +: 4])
                    SRC_TMR: v = tmr_r;
                    SRC_BUSY: v = run_r;
                    SRC_OVF: v = ovf_o;
                    default: v = trig_lvl_i[i];
                endcase
            end
            // polarity set means the asserted level is low
            assign tnxt[i] = v ^ trig_pol_i[i];
        end
    endgenerate
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_o <= '0;
            trig_oe_n_o <= '1;
            cc_o <= '0;
        end else begin
            trig_o <= tnxt;
            trig_oe_n_o <= ~(trig_dir_out_i & {~ext_alt_sel_i, {NBUS{1'b1}}});
            cc_o <= cc_sel_i & line_in[NTRIG-1:NBUS] | ~cc_sel_i & {NCC{tmr_r}};
        end
    end

    a_alt_no_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(ext_alt_sel_i[1]) |-> trig_oe_n_o[NBUS+1])
        else $error("alternate-source trigger drives its pin");
    a_cc_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(cc_sel_i[2]) |-> cc_o[2] == $past(line_in[NBUS+2]))
        else $error("camera control does not follow external trigger");
endmodule

//--- testbench/cafe_cam_model.sv
// camera model: four frames of five lines, eight pixels a line, per go_i rise
// assumes the bench raises go_i again only after the frames have been sent
`timescale 1ns/100ps
module cafe_cam_model (
    // pixel clock and run request
    input wire logic pclk_i,
    input wire logic go_i,
    // link outputs
    output logic [23:0] data_o,
    output logic fval_o,
    output logic lval_o,
    output logic dval_o
);
    int f, r, c, p;
    // pixel value packs frame, line and pixel so misplaced pixels show up
    initial begin
        {data_o, fval_o, lval_o, dval_o} = 27'h0000000;
        forever begin
            @(posedge go_i);
            for (f = 0; f < 4; f++) begin
                @(posedge pclk_i) fval_o <= 1'b1;
                for (r = 0; r < 5; r++) begin
                    for (c = 0; c < 9; c++) begin
                        p = c - (c > 3);
                        @(posedge pclk_i) lval_o <= 1'b1;
                        dval_o <= (c != 3);
                        data_o <= (c == 3) ? ~data_o : {16'h0000, 2'(f), 3'(r), 3'(p)};
                    end
                    // blanking data toggles so stale values never look valid
                    repeat (2) @(posedge pclk_i) {lval_o, dval_o, data_o} <= {2'h0, ~data_o};
                end
                repeat (4) @(posedge pclk_i) fval_o <= 1'b0;
            end
        end
    end
endmodule

//--- testbench/test_camera_acquisition_front_end.sv
// bench: window, region, binarise modes, skip and frame count, trigger routing
// assumes the camera model above on the link side
`timescale 1ns/100ps
module test_camera_acquisition_front_end;
    import cafe_pkg::*;
    logic clk_i = 0, nrst_i = 0, pclk_i = 0, cam_go = 0, cam_fval_i, cam_lval_i, cam_dval_i;
    logic [DW-1:0] cam_data_i, px_data_o;
    cafe_fmt_t fmt_i = F8X1;
    cafe_bin_t bin_mode_i = BIN_ON;
    logic [PW-1:0] thr_lo_i = 16'h0050, thr_hi_i = 16'h005a;
    logic [TAPS-1:0] hdir_i = 3'h0, vdir_i = 3'h0;
    logic [CW-1:0] win_x_i = 12'h001, win_w_i = 12'h006, win_y_i = 12'h001, win_h_i = 12'h003;
    logic [CW-1:0] roi_x_i = 12'h001, roi_w_i = 12'h004, roi_y_i = 12'h001, roi_h_i = 12'h002;
    logic [CW-1:0] nframes_i = 12'h002, nskip_i = 12'h001;
    logic sw_start_i = 0, px_ready_i = 1, tmr_go_i = 0, tmr_stop_i = 0, busy_o, ovf_o, px_valid_o;
    logic [TAPS*CW-1:0] px_col_o, px_row_o;
    logic [NTRIG-1:0] trig_i = 8'h40, trig_o, trig_oe_n_o, trig_pol_i = 8'h00;
    logic [NTRIG-1:0] trig_dir_out_i = 8'h30, trig_start_en_i = 8'h01, trig_lvl_i = 8'h10;
    logic [4*NTRIG-1:0] trig_src_i = 32'h11111111;
    logic [NEXT-1:0] alt_trig_i = 4'h0, ext_alt_sel_i = 4'h2;
    logic [15:0] tmr_period_i = 16'h0004, tmr_width_i = 16'h0002, tmr_count_i = 16'h0001;
    logic [NCC-1:0] cc_sel_i = 4'h4, cc_o;
    logic [7:0] v;
    int bad_count = 0, cmp_count = 0, n = 0, k;

    always #50 clk_i = ~clk_i;
    // 32 ns link clock, phase unrelated to the system clock
    always #16 pclk_i = ~pclk_i;

    cafe_cam_model cam (.pclk_i, .go_i(cam_go), .data_o(cam_data_i), .fval_o(cam_fval_i),
        .lval_o(cam_lval_i), .dval_o(cam_dval_i));
    cafe_top uut (.clk_i, .nrst_i, .pclk_i, .cam_data_i, .cam_fval_i, .cam_lval_i, .cam_dval_i,
        .fmt_i, .bin_mode_i, .thr_lo_i, .thr_hi_i, .hdir_i, .vdir_i, .win_x_i, .win_w_i,
        .win_y_i, .win_h_i, .roi_x_i, .roi_w_i, .roi_y_i, .roi_h_i, .nframes_i, .nskip_i,
        .sw_start_i, .busy_o, .ovf_o, .px_valid_o, .px_ready_i, .px_data_o, .px_col_o,
        .px_row_o, .trig_i, .trig_o, .trig_oe_n_o, .alt_trig_i, .ext_alt_sel_i, .trig_pol_i,
        .trig_dir_out_i, .trig_start_en_i, .trig_lvl_i, .trig_src_i, .tmr_go_i, .tmr_stop_i,
        .tmr_period_i, .tmr_width_i, .tmr_count_i, .cc_sel_i, .cc_o);

    task chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 2000 && busy_o !== lvl; i++) @(posedge clk_i);
        chk(busy_o, lvl);
    endtask

    // expected word n: frame 1 + n / 8 (frame 0 skipped), lines 2-3, pixels 2-5
    always @(posedge clk_i) begin
        if (px_valid_o === 1'b1 && px_ready_i) begin
            v = {2'(1 + n / 8), 3'(2 + (n % 8) / 4), 3'(2 + n % 4)};
            chk(px_data_o, (((v >= 8'h50) && (v <= 8'h5a)) == (bin_mode_i == BIN_ON)) ? 8'hff : 8'h00);
            chk(px_col_o[11:0], hdir_i[0] ? 3 - n % 4 : n % 4);
            chk(px_row_o[11:0], vdir_i[0] ? 1 - (n % 8) / 4 : (n % 8) / 4);
            n++;
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        // pin inputs pass two sync stages before the registered outputs follow
        repeat (4) @(posedge clk_i);
        chk(trig_oe_n_o, 8'hef);
        chk(trig_o[4], 1'b1);
        chk(cc_o[2], 1'b1);
        // one timer pulse two cycles wide, seen on camera control 0
        tmr_go_i <= 1'b1;
        @(posedge clk_i);
        tmr_go_i <= 1'b0;
        for (k = 0; k < 12; k++) begin
            @(posedge clk_i);
            n += cc_o[0];
        end
        chk(n, 2);
        n = 0;
        // run 1 starts from trigger line 0; run 2 stalls the stream into overflow
        for (k = 0; k < 3; k++) begin
            bin_mode_i <= (k == 1) ? BIN_INV : BIN_ON;
            hdir_i <= {2'h0, k == 2};
            vdir_i <= {2'h0, k == 2};
            nframes_i <= (k == 2) ? 12'h003 : 12'h002;
            px_ready_i <= (k != 2);
            if (k == 1)
                trig_i[0] <= 1'b1;
            else
                sw_start_i <= 1'b1;
            wait_busy(1'b1);
            sw_start_i <= 1'b0;
            trig_i[0] <= 1'b0;
            cam_go <= 1'b1;
            wait_busy(1'b0);
            cam_go <= 1'b0;
            px_ready_i <= 1'b1;
            // lets the camera finish its frames and the stream drain
            repeat (100) @(posedge clk_i);
            // a stalled run keeps sixteen fifo words plus the output register
            chk(n, (k == 2) ? 17 : 16);
            chk(ovf_o, k == 2);
            n = 0;
        end
        test_done;
    end

    // watchdog well beyond the timer check and three acquisitions of four frames
    initial begin
        #500us;
        bad_count++;
        test_done;
    end
endmodule
